// ---- logic/spi_tx_master.sv ----
// Serial transmit master with bus registers, byte buffer and link-clocked shifter.
//
// How it works
// - The byte count register reports how many bytes the last transaction moved, from 1 up to 0x1fff.
// - Bit order 0 shifts each byte out high bit first and bit order 1 shifts it low bit first.
// - Phase 0 samples on the leading clock edge and shifts on the trailing one, phase 1 the reverse.
// - Polarity 0 gives a clock idling low and active high, polarity 1 idling high and active low.
// - Once the buffer is used up while the transaction goes on, each further byte is the fill character.
// - Serial transmission begins within about one microsecond of the start command.
module spi_tx_master (
  // Bus clock, reset and freeze.
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        ce,
  // Register bus.
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Serial link.
  input  wire logic        link_clk,
  input  wire logic        miso,
  output logic             sck,
  output logic             mosi,
  output logic             csn
);

  // Bus-clock state.
  typedef struct packed {
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        dph_wr;
    logic [11:0] dph_addr;
    logic [2:0]  cfg;
    logic        list;
    logic [7:0]  fill;
    logic [4:0]  tx_len;
    logic [12:0] total;
    logic [12:0] byte_count;
    logic [7:0]  rx_last;
    logic        busy;
    logic        start_tgl;
    logic [2:0]  done_sync;
  } bus_state_t;

  // Link-clock state.
  typedef struct packed {
    logic [1:0]              ce_sync;
    logic [1:0]              start_sync;
    logic                    start_seen;
    logic [1:0]              cpol_sync;
    logic [1:0]              miso_sync;
    logic [2:0]              cfg;
    logic [7:0]              fill;
    logic [4:0]              tx_len;
    logic [12:0]             total;
    spi_tx_pkg::link_state_t st;
    logic                    sub;
    logic [2:0]              bitn;
    logic [12:0]             idx;
    logic [7:0]              shreg;
    logic [7:0]              rx;
    logic [12:0]             done_cnt;
    logic                    done_tgl;
    logic                    sck;
    logic                    mosi;
    logic                    csn;
  } link_st_t;

  localparam int START_CYCLES = spi_tx_pkg::START_CYCLES;

  bus_state_t bus_ff;
  bus_state_t nxt_bus;
  link_st_t   link_ff;
  link_st_t   nxt_link;
  logic [1:0] lrst_ff;
  logic       lrst_n;
  logic       aph;
  logic       done_evt;
  logic       start_evt;
  logic       lce;
  logic       mem_we;
  logic       mem_re;
  logic [7:0] mem_rdata;

  // Picks the outgoing bit of a byte for the programmed order.
  function automatic logic out_bit(input logic [7:0] b, input logic [2:0] n, input logic low_first);
    out_bit = low_first ? b[n] : b[spi_tx_pkg::BIT_LAST - n];
  endfunction

  // True when a byte address falls in the transmit buffer window.
  function automatic logic is_buf(input logic [11:0] a);
    is_buf = (a[11:spi_tx_pkg::BUF_SHIFT] == spi_tx_pkg::ADDR_BUF_BASE[11:spi_tx_pkg::BUF_SHIFT]);
  endfunction

  assign aph      = hsel && (htrans == spi_tx_pkg::HTRANS_NONSEQ) && hready;
  assign done_evt = bus_ff.done_sync[1] ^ bus_ff.done_sync[2];
  assign mem_we   = ce && bus_ff.dph_wr && is_buf(bus_ff.dph_addr) && !bus_ff.busy;

  // Bus side: zero-wait slave, registered read data, writes land in the data phase.
  always_comb begin
    nxt_bus = bus_ff;
    if (ce) begin
      nxt_bus.hreadyout = 1'b1;
      nxt_bus.hresp     = 1'b0;
      nxt_bus.done_sync = {bus_ff.done_sync[1:0], link_ff.done_tgl};
      nxt_bus.dph_wr    = aph && hwrite && (hsize == spi_tx_pkg::HSIZE_WORD);
      nxt_bus.dph_addr  = haddr[11:0];
      // Read data is prepared in the address phase so it stands from a flop in the data phase.
      nxt_bus.hrdata = 32'h0000_0000;
      if (aph && !hwrite) begin
        case (haddr[11:0])
          spi_tx_pkg::ADDR_TX_LEN:     nxt_bus.hrdata[4:0] = bus_ff.tx_len;
          spi_tx_pkg::ADDR_TOTAL:      nxt_bus.hrdata[12:0] = bus_ff.total;
          spi_tx_pkg::ADDR_BYTE_COUNT: nxt_bus.hrdata[12:0] = bus_ff.byte_count;
          spi_tx_pkg::ADDR_LIST:       nxt_bus.hrdata[spi_tx_pkg::LIST_BIT] = bus_ff.list;
          spi_tx_pkg::ADDR_CONFIG:     nxt_bus.hrdata[2:0] = bus_ff.cfg;
          spi_tx_pkg::ADDR_FILL:       nxt_bus.hrdata[7:0] = bus_ff.fill;
          spi_tx_pkg::ADDR_STATUS: begin
            nxt_bus.hrdata[spi_tx_pkg::STAT_BUSY] = bus_ff.busy;
            nxt_bus.hrdata[spi_tx_pkg::STAT_RX_LO +: 8] = bus_ff.rx_last;
          end
          default:                     nxt_bus.hrdata = 32'h0000_0000;
        endcase
      end
      // Settings are frozen while a transaction runs, since the link reads them unsynchronised.
      if (bus_ff.dph_wr && !bus_ff.busy) begin
        case (bus_ff.dph_addr)
          spi_tx_pkg::ADDR_TX_LEN: begin
            nxt_bus.tx_len = hwdata[spi_tx_pkg::BUF_AW] ? spi_tx_pkg::BUF_FULL : hwdata[4:0];
          end
          spi_tx_pkg::ADDR_TOTAL:  nxt_bus.total = hwdata[12:0];
          spi_tx_pkg::ADDR_LIST:   nxt_bus.list = hwdata[spi_tx_pkg::LIST_BIT];
          spi_tx_pkg::ADDR_CONFIG: nxt_bus.cfg = hwdata[2:0];
          spi_tx_pkg::ADDR_FILL:   nxt_bus.fill = hwdata[7:0];
          spi_tx_pkg::ADDR_START: begin
            if (hwdata[spi_tx_pkg::START_BIT] && (bus_ff.total != 13'h0000)) begin
              nxt_bus.busy      = 1'b1;
              nxt_bus.start_tgl = ~bus_ff.start_tgl;
            end
          end
          default: nxt_bus.busy = bus_ff.busy;
        endcase
      end
      // The count is taken only at the end of a transaction and held otherwise.
      if (done_evt) begin
        nxt_bus.byte_count = link_ff.done_cnt;
        nxt_bus.rx_last    = link_ff.rx;
        nxt_bus.busy       = 1'b0;
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      bus_ff           <= '0;
      bus_ff.hreadyout <= 1'b1;
    end else begin
      bus_ff <= nxt_bus;
    end
  end

  // Link reset: asserted at once, released on the link clock.
  always_ff @(posedge link_clk or negedge hresetn) begin
    if (!hresetn) begin
      lrst_ff <= 2'h0;
    end else begin
      lrst_ff <= {lrst_ff[0], 1'b1};
    end
  end
  assign lrst_n = lrst_ff[1];

  assign lce       = link_ff.ce_sync[1];
  assign start_evt = link_ff.start_sync[1] ^ link_ff.start_seen;
  assign mem_re    = lce && (link_ff.st == spi_tx_pkg::st_load);

  // Link side: the half0 and half1 states take two link cycles each so the synchronised input is caught at the sample edge.
  always_comb begin
    nxt_link         = link_ff;
    nxt_link.ce_sync = {link_ff.ce_sync[0], ce};
    if (lce) begin
      nxt_link.start_sync = {link_ff.start_sync[0], bus_ff.start_tgl};
      nxt_link.start_seen = link_ff.start_sync[1];
      nxt_link.cpol_sync  = {link_ff.cpol_sync[0], bus_ff.cfg[spi_tx_pkg::CFG_CPOL]};
      nxt_link.miso_sync  = {link_ff.miso_sync[0], miso};
      unique case (link_ff.st)
        spi_tx_pkg::st_idle: begin
          nxt_link.sck = link_ff.cpol_sync[1];
          nxt_link.csn = 1'b1;
          if (start_evt) begin
            // Bus settings are stable here: they cannot change while busy.
            nxt_link.cfg    = bus_ff.cfg;
            nxt_link.fill   = bus_ff.fill;
            nxt_link.tx_len = bus_ff.tx_len;
            nxt_link.total  = bus_ff.total;
            nxt_link.idx    = 13'h0000;
            nxt_link.csn    = 1'b0;
            nxt_link.st     = spi_tx_pkg::st_load;
          end
        end
        spi_tx_pkg::st_load: begin
          nxt_link.st = spi_tx_pkg::st_fetch;
        end
        spi_tx_pkg::st_fetch: begin
          // Past the buffered bytes the fill character goes out instead.
          if (link_ff.idx < {8'h00, link_ff.tx_len}) begin
            nxt_link.shreg = mem_rdata;
          end else begin
            nxt_link.shreg = link_ff.fill;
          end
          nxt_link.bitn = 3'h0;
          nxt_link.sub  = 1'b0;
          nxt_link.mosi = out_bit(nxt_link.shreg, 3'h0, link_ff.cfg[spi_tx_pkg::CFG_ORDER]);
          nxt_link.sck  = link_ff.cfg[spi_tx_pkg::CFG_CPOL] ^ link_ff.cfg[spi_tx_pkg::CFG_CPHA];
          nxt_link.st   = spi_tx_pkg::st_half0;
        end
        spi_tx_pkg::st_half0: begin
          nxt_link.sub = ~link_ff.sub;
          if (link_ff.sub) begin
            // Entering the second half is the sample edge in both phases.
            nxt_link.sck = link_ff.cfg[spi_tx_pkg::CFG_CPOL] ^ ~link_ff.cfg[spi_tx_pkg::CFG_CPHA];
            nxt_link.st  = spi_tx_pkg::st_half1;
          end
        end
        spi_tx_pkg::st_half1: begin
          nxt_link.sub = ~link_ff.sub;
          if (link_ff.sub) begin
            // The synchroniser output now holds the line as it stood at the sample edge.
            if (link_ff.cfg[spi_tx_pkg::CFG_ORDER] == spi_tx_pkg::LOW_BIT_LEADING) begin
              nxt_link.rx = {link_ff.miso_sync[1], link_ff.rx[7:1]};
            end else begin
              nxt_link.rx = {link_ff.rx[6:0], link_ff.miso_sync[1]};
            end
            if (link_ff.bitn == spi_tx_pkg::BIT_LAST) begin
              nxt_link.idx = 13'(link_ff.idx + spi_tx_pkg::CNT_ONE);
              nxt_link.sck = link_ff.cfg[spi_tx_pkg::CFG_CPOL];
              if (nxt_link.idx == link_ff.total) begin
                nxt_link.st = spi_tx_pkg::st_tail;
              end else begin
                nxt_link.st = spi_tx_pkg::st_load;
              end
            end else begin
              nxt_link.bitn = 3'(link_ff.bitn + spi_tx_pkg::BIT_ONE);
              nxt_link.sck  = link_ff.cfg[spi_tx_pkg::CFG_CPOL] ^ link_ff.cfg[spi_tx_pkg::CFG_CPHA];
              nxt_link.mosi = out_bit(link_ff.shreg, nxt_link.bitn, link_ff.cfg[spi_tx_pkg::CFG_ORDER]);
              nxt_link.st   = spi_tx_pkg::st_half0;
            end
          end
        end
        spi_tx_pkg::st_tail: begin
          // Count and toggle change together; the bus side reads the count only after the toggle crossed.
          nxt_link.csn      = 1'b1;
          nxt_link.done_cnt = link_ff.idx;
          nxt_link.done_tgl = ~link_ff.done_tgl;
          nxt_link.st       = spi_tx_pkg::st_idle;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk or negedge lrst_n) begin
    if (!lrst_n) begin
      link_ff     <= '0;
      link_ff.st  <= spi_tx_pkg::st_idle;
      link_ff.csn <= 1'b1;
    end else begin
      link_ff <= nxt_link;
    end
  end

  tx_byte_mem u_buf (
    .wr_clk  (hclk),
    .wr_en   (mem_we),
    .wr_addr (bus_ff.dph_addr[spi_tx_pkg::BUF_SHIFT-1:2]),
    .wr_data (hwdata[7:0]),
    .rd_clk  (link_clk),
    .rd_en   (mem_re),
    .rd_addr (link_ff.idx[spi_tx_pkg::BUF_AW-1:0]),
    .rd_data (mem_rdata)
  );

  // Outputs come straight from the state flops.
  assign hrdata    = bus_ff.hrdata;
  assign hreadyout = bus_ff.hreadyout;
  assign hresp     = bus_ff.hresp;
  assign sck       = link_ff.sck;
  assign mosi      = link_ff.mosi;
  assign csn       = link_ff.csn;

  // The fetch step of a byte that lies past the buffered bytes.
  sequence fetch_fill_s;
    (link_ff.st == spi_tx_pkg::st_fetch) && lce && (link_ff.idx >= {8'h00, link_ff.tx_len});
  endsequence

  // The start command as the bus side issues it, before any crossing delay.
  sequence start_seen_s;
    $changed(bus_ff.start_tgl);
  endsequence

  chk_count_nonzero: assert property (@(posedge hclk) disable iff (!hresetn)
    done_evt && ce |=> (bus_ff.byte_count != 13'h0000) && (bus_ff.byte_count <= spi_tx_pkg::MAX_COUNT))
    else $error("byte count outside 1 to 0x1fff after a transaction");

  chk_order_high: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (link_ff.st == spi_tx_pkg::st_half0) && (link_ff.cfg[spi_tx_pkg::CFG_ORDER] == spi_tx_pkg::HIGH_BIT_LEADING)
    |-> mosi == link_ff.shreg[spi_tx_pkg::BIT_LAST - link_ff.bitn])
    else $error("data bit not taken high bit first");

  chk_order_low: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (link_ff.st == spi_tx_pkg::st_half1) && (link_ff.cfg[spi_tx_pkg::CFG_ORDER] == spi_tx_pkg::LOW_BIT_LEADING)
    |-> mosi == link_ff.shreg[link_ff.bitn])
    else $error("data bit not taken low bit first");

  chk_sample_edge: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (link_ff.st == spi_tx_pkg::st_half1) |-> $stable(mosi) &&
    (sck == (link_ff.cfg[spi_tx_pkg::CFG_CPOL] ^ ~link_ff.cfg[spi_tx_pkg::CFG_CPHA])))
    else $error("clock level or data wrong around the sample edge");

  chk_idle_level: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (link_ff.st == spi_tx_pkg::st_tail) && lce |-> (sck == link_ff.cfg[spi_tx_pkg::CFG_CPOL]) ##1 csn)
    else $error("clock not at its idle level at the end of a transaction");

  chk_fill_char: assert property (@(posedge link_clk) disable iff (!lrst_n)
    fetch_fill_s |=> (link_ff.shreg == link_ff.fill) && (link_ff.st == spi_tx_pkg::st_half0))
    else $error("fill character not used past the buffer end");

  chk_start_latency: assert property (@(posedge hclk) disable iff (!hresetn)
    start_seen_s |-> ##[1:START_CYCLES] !csn)
    else $error("transmission did not begin in time after start");

  chk_count_hold: assert property (@(posedge hclk) disable iff (!hresetn)
    !done_evt |=> $stable(bus_ff.byte_count))
    else $error("byte count changed outside the end of a transaction");

  chk_tail_count: assert property (@(posedge link_clk) disable iff (!lrst_n)
    (link_ff.st == spi_tx_pkg::st_tail) && lce |=> (link_ff.done_cnt == link_ff.total) ##1 $stable(link_ff.done_cnt))
    else $error("transaction count not captured at the end");

endmodule

// ---- logic/spi_tx_pkg.sv ----
// Shared constants and types of the serial transmit master.
package spi_tx_pkg;

  // Register byte addresses within the block (low twelve address bits).
  localparam logic [11:0] ADDR_START      = 12'h010;
  localparam logic [11:0] ADDR_TX_LEN     = 12'h014;
  localparam logic [11:0] ADDR_TOTAL      = 12'h018;
  localparam logic [11:0] ADDR_STATUS     = 12'h01c;
  localparam logic [11:0] ADDR_BUF_BASE   = 12'h200;
  localparam logic [11:0] ADDR_BYTE_COUNT = 12'h54c;
  localparam logic [11:0] ADDR_LIST       = 12'h550;
  localparam logic [11:0] ADDR_CONFIG     = 12'h554;
  localparam logic [11:0] ADDR_FILL       = 12'h5c0;

  // Transmit buffer geometry.
  localparam int          BUF_DEPTH  = 16;
  localparam int          BUF_AW     = 4;
  localparam int          BUF_SHIFT  = BUF_AW + 2;
  localparam logic [4:0]  BUF_FULL   = 5'h10;

  // Field positions.
  localparam int          CFG_ORDER  = 0;
  localparam int          CFG_CPHA   = 1;
  localparam int          CFG_CPOL   = 2;
  localparam int          LIST_BIT   = 0;
  localparam int          START_BIT  = 0;
  localparam int          STAT_BUSY  = 0;
  localparam int          STAT_RX_LO = 8;

  // Field values and widths.
  localparam logic        HIGH_BIT_LEADING      = 1'b0;
  localparam logic        LOW_BIT_LEADING       = 1'b1;
  localparam logic        ARRAY_DESCRIPTOR_MODE = 1'b1;
  localparam int          CNT_W      = 13;
  localparam logic [12:0] MAX_COUNT  = 13'h1fff;
  localparam logic [12:0] CNT_ONE    = 13'h0001;
  localparam logic [2:0]  BIT_LAST   = 3'h7;
  localparam logic [2:0]  BIT_ONE    = 3'h1;
  localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0]  HSIZE_WORD = 3'h2;

  // Timing: start-to-transmission time and the two clock periods.
  localparam int          START_TIME_NS  = 1000;
  localparam int          HCLK_PERIOD_NS = 10;
  localparam int          LINK_PERIOD_NS = 64;
  localparam int          START_CYCLES   = START_TIME_NS / HCLK_PERIOD_NS;
  localparam int          START_LINK_MAX = START_TIME_NS / LINK_PERIOD_NS;

  // Link-side sequencer states.
  typedef enum logic [2:0] {
    st_idle,
    st_load,
    st_fetch,
    st_half0,
    st_half1,
    st_tail
  } link_state_t;

endpackage

// ---- logic/tx_byte_mem.sv ----
// Transmit byte buffer: written from the bus clock, read from the link clock.
module tx_byte_mem (
  // Write side, bus clock.
  input  wire logic       wr_clk,
  input  wire logic       wr_en,
  input  wire logic [3:0] wr_addr,
  input  wire logic [7:0] wr_data,
  // Read side, link clock.
  input  wire logic       rd_clk,
  input  wire logic       rd_en,
  input  wire logic [3:0] rd_addr,
  output logic      [7:0] rd_data
);

  logic [7:0] mem [spi_tx_pkg::BUF_DEPTH];

  // Software fills the buffer only while the link is idle, so the ports never collide.
  always_ff @(posedge wr_clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // Registered read keeps the link path short.
  always_ff @(posedge rd_clk) begin
    if (rd_en) begin
      rd_data <= mem[rd_addr];
    end
  end

endmodule

// ---- tb/spi_slave_model.sv ----
// Behavioural serial slave that records the bits it samples and answers on miso.
module spi_slave_model (
  // Link pins.
  input  wire logic link_clk,
  input  wire logic sck,
  input  wire logic mosi,
  input  wire logic csn,
  // Mode the bench has programmed.
  input  wire logic cpol,
  input  wire logic cpha,
  // Reply line.
  output logic      miso
);
  timeunit 1ns;
  timeprecision 1ps;

  logic       bits[$];
  int         idle_bad;
  logic [7:0] reply;

  // Start quiet with a fixed reply pattern.
  initial begin
    miso = 1'b0;
    idle_bad = 0;
    reply = 8'h3c;
  end

  // The clock must sit at its idle level whenever select changes.
  always @(csn) begin
    if ($time > 0 && sck !== cpol) idle_bad++;
  end

  // Sample on the leading edge in phase 0 and the trailing one in phase 1.
  always @(sck) begin
    if (csn === 1'b0 && sck === ~(cpol ^ cpha)) bits.push_back(mosi);
    else if (csn === 1'b0) begin
      reply = {reply[6:0], reply[7]};
      miso <= reply[7];
    end
  end

  // Outside frames miso toggles so a stale value can never look valid.
  always @(posedge link_clk) begin
    if (csn !== 1'b0) miso <= ~miso;
  end
endmodule

// ---- tb/testbench.sv ----
// Self-checking bench of the serial transmit master: registers, frames, fill and count.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;

  logic        hclk, hresetn, link_clk, hsel, hwrite, miso, sck, mosi, csn, hreadyout, hresp, ce, resp;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0]  htrans;
  logic [2:0]  hsize, mode;
  int          mismatches, n_compared;

  // Bus clock at 100 MHz; the 64 ns link clock never has an edge on a rising bus clock edge.
  always #5 hclk = ~hclk;
  always #32 link_clk = ~link_clk;

  spi_tx_master i_dut (
    .hclk(hclk), .hresetn(hresetn), .ce(ce), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .link_clk(link_clk), .miso(miso), .sck(sck),
    .mosi(mosi), .csn(csn)
  );

  spi_slave_model i_slave (
    .link_clk(link_clk), .sck(sck), .mosi(mosi), .csn(csn), .cpol(mode[2]), .cpha(mode[1]),
    .miso(miso)
  );

  // Compare and count.
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  // Print the counts and the verdict, then stop.
  task automatic close_out();
    $display("compared %0d, mismatched %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  // Hold the current phase until hready is seen high at a rising edge.
  task automatic wait_ready(output logic [31:0] q);
    logic r;
    for (int n = 0; n < 50; n++) begin
      @(negedge hclk);
      q = hrdata;
      r = hreadyout;
      resp = hresp;
      @(posedge hclk);
      if (r === 1'b1) return;
    end
    mismatches++;
    close_out();
  endtask

  // One single word transfer; read data is what stands at the edge ending the data phase.
  task automatic bus(input logic [11:0] a, input logic wr, input logic [31:0] d, output logic [31:0] q);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= spi_tx_pkg::HTRANS_NONSEQ;
    haddr <= {20'h00000, a};
    hwrite <= wr;
    hsize <= spi_tx_pkg::HSIZE_WORD;
    wait_ready(q);
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready(q);
    check({31'h0, resp}, 32'h0, "okay response");
  endtask

  // Reset values, access kinds and an unmapped place.
  task automatic t_regs();
    logic [31:0] q;
    bus(spi_tx_pkg::ADDR_BYTE_COUNT, 1'b0, 32'h0, q); check(q, 32'h0, "count reset");
    bus(spi_tx_pkg::ADDR_LIST, 1'b0, 32'h0, q); check(q, 32'h0, "list reset");
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b0, 32'h0, q); check(q, 32'h0, "config reset");
    bus(spi_tx_pkg::ADDR_FILL, 1'b0, 32'h0, q); check(q, 32'h0, "fill reset");
    bus(spi_tx_pkg::ADDR_LIST, 1'b1, 32'hffffffff, q);
    bus(spi_tx_pkg::ADDR_LIST, 1'b0, 32'h0, q); check(q, 32'h1, "list rw");
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b1, 32'hffffffff, q);
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b0, 32'h0, q); check(q, 32'h7, "config rw");
    bus(spi_tx_pkg::ADDR_FILL, 1'b1, 32'hffffffff, q);
    bus(spi_tx_pkg::ADDR_FILL, 1'b0, 32'h0, q); check(q, 32'hff, "fill rw");
    bus(spi_tx_pkg::ADDR_BYTE_COUNT, 1'b1, 32'h5, q);
    bus(spi_tx_pkg::ADDR_BYTE_COUNT, 1'b0, 32'h0, q); check(q, 32'h0, "count read only");
    bus(12'h7f0, 1'b1, 32'h1234, q);
    bus(12'h7f0, 1'b0, 32'h0, q); check(q, 32'h0, "unmapped");
    $display("test registers done");
  endtask

  // With the enable low no transfer is taken, so the earlier setting must survive.
  task automatic t_freeze();
    logic [31:0] q;
    @(posedge hclk);
    ce <= 1'b0;
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b1, 32'h2, q);
    ce <= 1'b1;
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b0, 32'h0, q); check(q, 32'h7, "write taken while frozen");
    $display("test freeze done");
  endtask

  // One buffered byte then one fill byte in the given mode; count, timing and wire bits.
  task automatic t_frame(input logic [2:0] cfg, input logic [7:0] b0, input logic [7:0] fill, input int prev);
    logic [31:0] q;
    logic [7:0]  e;
    int          n;
    mode <= cfg;
    bus(spi_tx_pkg::ADDR_CONFIG, 1'b1, {29'h0, cfg}, q);
    bus(spi_tx_pkg::ADDR_FILL, 1'b1, {24'h0, fill}, q);
    bus(spi_tx_pkg::ADDR_BUF_BASE, 1'b1, {24'h0, b0}, q);
    bus(spi_tx_pkg::ADDR_TX_LEN, 1'b1, 32'h1, q);
    bus(spi_tx_pkg::ADDR_TOTAL, 1'b1, 32'h2, q);
    i_slave.bits.delete();
    bus(spi_tx_pkg::ADDR_START, 1'b1, 32'h1, q);
    for (n = 0; n < spi_tx_pkg::START_CYCLES && csn !== 1'b0; n++) @(posedge hclk);
    check({31'h0, csn}, 32'h0, "start latency");
    bus(spi_tx_pkg::ADDR_BYTE_COUNT, 1'b0, 32'h0, q); check(q, prev, "count held in flight");
    for (n = 0; n < 1000; n++) begin
      bus(spi_tx_pkg::ADDR_STATUS, 1'b0, 32'h0, q);
      if (q[spi_tx_pkg::STAT_BUSY] === 1'b0) break;
    end
    if (n == 1000) begin
      mismatches++;
      close_out();
    end
    bus(spi_tx_pkg::ADDR_BYTE_COUNT, 1'b0, 32'h0, q); check(q, 32'h2, "count at end");
    check(i_slave.bits.size(), 32'd16, "bit count");
    for (int i = 0; i < 16; i++) begin
      e = (i < 8) ? b0 : fill;
      check({31'h0, i_slave.bits[i]}, {31'h0, cfg[0] ? e[i % 8] : e[7 - i % 8]}, "wire bit");
    end
    check(i_slave.idle_bad, 32'd0, "idle level");
    $display("test frame mode %0d done", cfg);
  endtask

  // Reset, then every order, phase and polarity combination.
  initial begin
    hclk = 1'b0;
    link_clk = 1'b0;
    hresetn = 1'b0;
    {hsel, hwrite, haddr, hwdata, htrans, hsize, mode} = '0;
    ce = 1'b1;
    resp = 1'b0;
    mismatches = 0;
    n_compared = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs();
    t_freeze();
    for (int c = 0; c < 8; c++) begin
      t_frame(c[2:0], 8'hc1 + c[7:0], 8'h36 ^ c[7:0], (c == 0) ? 0 : 2);
    end
    close_out();
  end
endmodule
